// [logic/dpt_top.sv]
`timescale 1ns/1ns
`include "dpt_defs.svh"
module dpt_top
  import dpt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // pins
  input wire logic external_timer_clock_in_i,
  output logic pwm0_o,
  output logic pwm1_o,
  output logic irq0_o,
  output logic irq1_o
);
  dpt_bus_t bus;
  logic [25:0] cfg_r, cfg_nxt;
  logic [8:0] ctl_r, ctl_nxt;
  logic [15:0] cmp0_r, cmp0_nxt, cmp1_r, cmp1_nxt;
  logic [15:0] rld0_r, rld0_nxt, rld1_r, rld1_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] ps_cnt_r, ps_cnt_nxt;
  logic [3:0] div_r, div_nxt;
  logic [3:0] tick_r, tick_nxt;
  logic [2:0] ext_sync_r, ext_sync_nxt;
  logic ext_tick_r, ext_tick_nxt;
  logic [7:0] dz_cnt_r, dz_cnt_nxt;
  logic pwm0_r, pwm0_nxt, pwm1_r, pwm1_nxt;
  logic irq0_r, irq0_nxt, irq1_r, irq1_nxt;
  logic w0_prev_r, w0_prev_nxt;
  dpt_chan_cfg_t c0, c1;
  logic [15:0] cnt0, cnt1;
  logic wave0, wave1, exp0, exp1;

  function automatic logic hit(input logic [5:0] a);
    hit = bus.wr && (bus.addr == a);
  endfunction

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // register writes
  always_comb begin
    cfg_nxt = cfg_r;
    ctl_nxt = ctl_r;
    cmp0_nxt = cmp0_r;
    cmp1_nxt = cmp1_r;
    rld0_nxt = rld0_r;
    rld1_nxt = rld1_r;
    cfg_nxt[`DPT_CFG_CLR1] = 1'b0;
    cfg_nxt[`DPT_CFG_CLR0] = 1'b0;
    ctl_nxt[`DPT_CTL_LD1] = 1'b0;
    ctl_nxt[`DPT_CTL_LD0] = 1'b0;
    if (hit(`DPT_A_CFG)) begin
      cfg_nxt = bus.wdata[25:0];
    end
    if (hit(`DPT_A_CTL)) begin
      ctl_nxt = bus.wdata[8:0];
    end
    if (hit(`DPT_A_CMP0)) begin
      cmp0_nxt = bus.wdata[15:0];
    end
    if (hit(`DPT_A_RLD0)) begin
      rld0_nxt = bus.wdata[15:0];
    end
    if (hit(`DPT_A_CMP1)) begin
      cmp1_nxt = bus.wdata[15:0];
    end
    if (hit(`DPT_A_RLD1)) begin
      rld1_nxt = bus.wdata[15:0];
    end
  end

  // read data, one cycle later
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (bus.rd) begin
      unique case (bus.addr)
        `DPT_A_CFG: rdata_nxt = {6'h00, cfg_r};
        `DPT_A_CTL: rdata_nxt = {23'h0, ctl_r};
        `DPT_A_CMP0: rdata_nxt = {16'h0000, cmp0_r};
        `DPT_A_RLD0: rdata_nxt = {16'h0000, rld0_r};
        `DPT_A_CNT0: rdata_nxt = {16'h0000, cnt0};
        `DPT_A_CMP1: rdata_nxt = {16'h0000, cmp1_r};
        `DPT_A_RLD1: rdata_nxt = {16'h0000, rld1_r};
        `DPT_A_CNT1: rdata_nxt = {16'h0000, cnt1};
        `DPT_A_RAW: rdata_nxt = {30'h0, exp1, exp0};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // prescaler and divider ticks
  always_comb begin
    ps_cnt_nxt = ps_cnt_r + 8'h01;
    div_nxt = div_r;
    tick_nxt = 4'h0;
    if (ps_cnt_r >= cfg_r[`DPT_CFG_PS_HI:`DPT_CFG_PS_LO]) begin
      ps_cnt_nxt = 8'h00;
      div_nxt = div_r + 4'h1;
      tick_nxt[0] = div_r[0];
      tick_nxt[1] = &div_r[1:0];
      tick_nxt[2] = &div_r[2:0];
      tick_nxt[3] = &div_r[3:0];
    end
    ext_sync_nxt = {ext_sync_r[1:0], external_timer_clock_in_i};
    ext_tick_nxt = ext_sync_r[1] && !ext_sync_r[2];
  end

  always_comb begin
    c0 = '{match: cmp0_r, reload: rld0_r,
      sel: cfg_r[`DPT_CFG_SEL0_HI:`DPT_CFG_SEL0_LO],
      rpt: ctl_r[`DPT_CTL_RPT0], inv: ctl_r[`DPT_CTL_INV0],
      load: ctl_r[`DPT_CTL_LD0], run: ctl_r[`DPT_CTL_RUN0],
      clr: cfg_r[`DPT_CFG_CLR0]};
    c1 = '{match: cmp1_r, reload: rld1_r,
      sel: cfg_r[`DPT_CFG_SEL1_HI:`DPT_CFG_SEL1_LO],
      rpt: ctl_r[`DPT_CTL_RPT1], inv: ctl_r[`DPT_CTL_INV1],
      load: ctl_r[`DPT_CTL_LD1], run: ctl_r[`DPT_CTL_RUN1],
      clr: cfg_r[`DPT_CFG_CLR1]};
  end

  dpt_chan u_chan0 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(c0),
    .tick_i(tick_r),
    .ext_tick_i(ext_tick_r),
    .count_o(cnt0),
    .wave_o(wave0),
    .expiry_o(exp0)
  );

  dpt_chan u_chan1 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(c1),
    .tick_i(tick_r),
    .ext_tick_i(ext_tick_r),
    .count_o(cnt1),
    .wave_o(wave1),
    .expiry_o(exp1)
  );

  // outputs, dead zone and interrupts
  always_comb begin
    w0_prev_nxt = wave0;
    dz_cnt_nxt = dz_cnt_r;
    pwm0_nxt = wave0;
    pwm1_nxt = wave1;
    if (ctl_r[`DPT_CTL_DZEN]) begin
      if (wave0 != w0_prev_r) begin
        dz_cnt_nxt = cfg_r[`DPT_CFG_DZ_HI:`DPT_CFG_DZ_LO];
      end else if (dz_cnt_r != 8'h00) begin
        dz_cnt_nxt = dz_cnt_r - 8'h01;
      end
      if (wave0 != w0_prev_r || dz_cnt_r != 8'h00) begin
        pwm0_nxt = 1'b0;
        pwm1_nxt = 1'b0;
      end else begin
        pwm1_nxt = !wave0;
      end
    end else begin
      dz_cnt_nxt = 8'h00;
    end
    irq0_nxt = exp0 && !cfg_r[`DPT_CFG_MSK_LO];
    irq1_nxt = exp1 && !cfg_r[`DPT_CFG_MSK_HI];
  end

  // register file
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= `DPT_CFG_RST;
      ctl_r <= `DPT_CTL_RST;
      cmp0_r <= 16'h0000;
      cmp1_r <= 16'h0000;
      rld0_r <= 16'h0000;
      rld1_r <= 16'h0000;
    end else begin
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      cmp0_r <= cmp0_nxt;
      cmp1_r <= cmp1_nxt;
      rld0_r <= rld0_nxt;
      rld1_r <= rld1_nxt;
    end
  end

  // read data
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // prescaler, dividers and external clock sync
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ps_cnt_r <= 8'h00;
      div_r <= 4'h0;
      tick_r <= 4'h0;
      ext_sync_r <= 3'h0;
      ext_tick_r <= 1'b0;
    end else begin
      ps_cnt_r <= ps_cnt_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      ext_sync_r <= ext_sync_nxt;
      ext_tick_r <= ext_tick_nxt;
    end
  end

  // outputs, dead zone and interrupts
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dz_cnt_r <= 8'h00;
      pwm0_r <= 1'b0;
      pwm1_r <= 1'b0;
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      w0_prev_r <= 1'b0;
    end else begin
      dz_cnt_r <= dz_cnt_nxt;
      pwm0_r <= pwm0_nxt;
      pwm1_r <= pwm1_nxt;
      irq0_r <= irq0_nxt;
      irq1_r <= irq1_nxt;
      w0_prev_r <= w0_prev_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign pwm0_o = pwm0_r;
  assign pwm1_o = pwm1_r;
  assign irq0_o = irq0_r;
  assign irq1_o = irq1_r;
endmodule

// [logic/dpt_defs.svh]
// How it works
// - writing one to a timeout-clear bit clears that flag; the bit self-clears
// - two mask bits gate the timer interrupts; one masks; reset value both set
// - clock select 000..011 picks prescaled clock /2,/4,/8,/16; 1xx external
// - eight-bit dead-zone length sets the gap between complementary outputs
// - repeat bit zero gives one-shot, one gives auto-reload interval mode
// - inverter bit set inverts the channel output, clear passes it through
// - writing one to manual-load loads counter from reload value; zero nothing
// - run bit set lets the timer count; clear holds it stopped
// - dead-zone enable bit switches dead-zone insertion on or off
// - live count of each timer is readable in a read-only register
// - raw flag register: bit 1 timer 1 timeout, bit 0 timer 0 timeout
`ifndef DPT_DEFS_SVH
`define DPT_DEFS_SVH
`define DPT_A_CFG 6'h00
`define DPT_A_CTL 6'h04
`define DPT_A_CMP0 6'h08
`define DPT_A_RLD0 6'h0c
`define DPT_A_CNT0 6'h10
`define DPT_A_CMP1 6'h14
`define DPT_A_RLD1 6'h18
`define DPT_A_CNT1 6'h1c
`define DPT_A_RAW 6'h20
`define DPT_CFG_RST 26'hc00000
`define DPT_CFG_CLR1 25
`define DPT_CFG_CLR0 24
`define DPT_CFG_MSK_HI 23
`define DPT_CFG_MSK_LO 22
`define DPT_CFG_SEL1_HI 21
`define DPT_CFG_SEL1_LO 19
`define DPT_CFG_SEL0_HI 18
`define DPT_CFG_SEL0_LO 16
`define DPT_CFG_DZ_HI 15
`define DPT_CFG_DZ_LO 8
`define DPT_CFG_PS_HI 7
`define DPT_CFG_PS_LO 0
`define DPT_CTL_RST 9'h0
`define DPT_CTL_RPT1 8
`define DPT_CTL_INV1 7
`define DPT_CTL_LD1 6
`define DPT_CTL_RUN1 5
`define DPT_CTL_DZEN 4
`define DPT_CTL_RPT0 3
`define DPT_CTL_INV0 2
`define DPT_CTL_LD0 1
`define DPT_CTL_RUN0 0
`define DPT_SEL_EXT 2
`endif

// [logic/dpt_pkg.sv]
package dpt_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dpt_bus_t;
  typedef struct packed {
    logic [15:0] match;
    logic [15:0] reload;
    logic [2:0] sel;
    logic rpt;
    logic inv;
    logic load;
    logic run;
    logic clr;
  } dpt_chan_cfg_t;
endpackage

// [logic/dpt_chan.sv]
`timescale 1ns/1ns
`include "dpt_defs.svh"
module dpt_chan
  import dpt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire dpt_chan_cfg_t cfg_i,
  input wire logic [3:0] tick_i,
  input wire logic ext_tick_i,
  // state
  output logic [15:0] count_o,
  output logic wave_o,
  output logic expiry_o
);
  logic [15:0] cnt_r, cnt_nxt;
  logic wave_r, wave_nxt;
  logic exp_r, exp_nxt;
  logic done_r, done_nxt;
  logic tick;

  always_comb begin
    if (cfg_i.sel[`DPT_SEL_EXT]) begin
      tick = ext_tick_i;
    end else begin
      tick = tick_i[cfg_i.sel[1:0]];
    end
    cnt_nxt = cnt_r;
    wave_nxt = wave_r;
    exp_nxt = exp_r;
    done_nxt = done_r;
    if (!cfg_i.run) begin
      done_nxt = 1'b0;
    end
    if (cfg_i.load) begin
      cnt_nxt = cfg_i.reload;
      done_nxt = 1'b0;
    end else if (cfg_i.run && !done_r && tick) begin
      if (cnt_r == 16'h0000) begin
        exp_nxt = 1'b1;
        if (cfg_i.rpt) begin
          cnt_nxt = cfg_i.reload;
        end else begin
          done_nxt = 1'b1;
        end
      end else begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_nxt == cfg_i.match) begin
          wave_nxt = !wave_r;
        end
      end
    end
    if (cfg_i.clr && !(exp_nxt && !exp_r)) begin
      exp_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 16'h0000;
      wave_r <= 1'b0;
      exp_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      wave_r <= wave_nxt;
      exp_r <= exp_nxt;
      done_r <= done_nxt;
    end
  end

  assign count_o = cnt_r;
  assign wave_o = wave_r ^ cfg_i.inv;
  assign expiry_o = exp_r;
endmodule

// [tb/dpt_top_asserts.sv]
`timescale 1ns/1ns
module dpt_top_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // pins
  input wire logic external_timer_clock_in_i,
  input wire logic pwm0_o,
  input wire logic pwm1_o,
  input wire logic irq0_o,
  input wire logic irq1_o
);
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  always_comb begin
    mask_nxt = mask_r;
    if (wr_i && addr_i == 6'h00) begin
      mask_nxt = wdata_i[23:22];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_r <= 2'h3;
    end else begin
      mask_r <= mask_nxt;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_clr0;
    wr_i && addr_i == 6'h00 && wdata_i[24];
  endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not idle");
  a_unmapped_zero: assert property (rd_i && addr_i > 6'h20 |=> !rdata_o)
    else $error("unmapped read not zero");
  a_raw_reserved: assert property (
    rd_i && addr_i == 6'h20 |=> rdata_o[31:2] == 30'h0)
    else $error("raw flag reserved bits set");
  a_load_selfclr: assert property (
    rd_i && addr_i == 6'h04 && !$past(wr_i) |=> rdata_o[6:0] ==? 7'b0xxxx0x)
    else $error("load bit not self cleared");
  a_clear_selfclr: assert property (
    rd_i && addr_i == 6'h00 && !$past(wr_i) |=> rdata_o[25:24] == 2'h0)
    else $error("clear bit not self cleared");
  a_mask_gate0: assert property (
    mask_r[0] && $past(mask_r[0]) |-> !irq0_o)
    else $error("masked irq0 high");
  a_mask_gate1: assert property (
    mask_r[1] && $past(mask_r[1]) |-> !irq1_o)
    else $error("masked irq1 high");
  a_clear_irq: assert property (s_clr0 |-> ##3 !irq0_o)
    else $error("irq0 not cleared");
endmodule
bind dpt_top dpt_top_asserts u_dpt_top_asserts (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o),
  .external_timer_clock_in_i(external_timer_clock_in_i),
  .pwm0_o(pwm0_o), .pwm1_o(pwm1_o), .irq0_o(irq0_o), .irq1_o(irq1_o));

// [tb/dpt_pwm_load.sv]
`timescale 1ns/1ns
module dpt_pwm_load (
  // clock
  input wire logic clk_i,
  // pins from the block
  input wire logic pwm0_i,
  input wire logic pwm1_i,
  // pin to the block, edge count to the testbench
  output logic ext_clk_o,
  output logic [15:0] edges0_o
);
  logic last_r;
  initial begin
    ext_clk_o = 1'b0;
    edges0_o = 16'h0;
    last_r = 1'b0;
  end
  // counts pwm0 transitions seen by the load
  always @(posedge clk_i) begin
    last_r <= pwm0_i;
    if (pwm0_i !== last_r) begin
      edges0_o <= edges0_o + 16'h1;
    end
  end
  // timer clock runs only within a burst, low between
  task automatic burst(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b0;
    end
  endtask
endmodule

// [tb/dpt_top_tb_top.sv]
`timescale 1ns/1ns
module dpt_top_tb_top;
  logic clk, rst_n, wr, rd, ext, pwm0, pwm1, irq0, irq1, p;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, a, b;
  logic [15:0] edges0;
  int errors, total_checks, div;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dpt_top u_dpt_top (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .external_timer_clock_in_i(ext), .pwm0_o(pwm0), .pwm1_o(pwm1),
    .irq0_o(irq0), .irq1_o(irq1));
  dpt_pwm_load u_dpt_pwm_load (.clk_i(clk), .pwm0_i(pwm0), .pwm1_i(pwm1),
    .ext_clk_o(ext), .edges0_o(edges0));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [5:0] ad, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_val(input logic [5:0] ad, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rd_reg(input logic [5:0] ad, input logic [31:0] exp);
    logic [31:0] v;
    rd_val(ad, v);
    chk(v, exp);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    test_done();
  end
  initial begin
    {rst_n, wr, rd, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd_reg(6'(i * 4), i == 0 ? 32'h00c00000 : 32'h0);
    end
    wr_reg(6'h08, 32'hffff1234);
    rd_reg(6'h08, 32'h1234);
    wr_reg(6'h10, 32'h55);
    rd_reg(6'h10, 32'h0);
    tend("registers");
    for (int k = 0; k < 5; k++) begin
      div = k < 4 ? 2 << k : 4;
      wr_reg(6'h00, 32'h00c00000 | (k == 4 ? 32'h1 : 32'(k) << 16));
      wr_reg(6'h0c, 32'hffff);
      wr_reg(6'h04, 32'h3);
      rd_val(6'h10, a);
      repeat (30) @(posedge clk);
      rd_val(6'h10, b);
      chk(a - b, 32'(32 / div));
    end
    wr_reg(6'h04, 32'h0);
    tend("dividers");
    wr_reg(6'h0c, 32'h5);
    wr_reg(6'h04, 32'h2);
    cyc(10);
    rd_reg(6'h10, 32'h5);
    rd_reg(6'h04, 32'h0);
    tend("load");
    wr_reg(6'h00, 32'h00800000);
    wr_reg(6'h08, 32'h1);
    wr_reg(6'h0c, 32'h3);
    a = {16'h0, edges0};
    wr_reg(6'h04, 32'h3);
    cyc(40);
    rd_reg(6'h20, 32'h1);
    chk_pin(irq0, 1'b1);
    rd_reg(6'h10, 32'h0);
    chk({16'h0, edges0} - a, 32'h1);
    wr_reg(6'h00, 32'h01800000);
    rd_reg(6'h00, 32'h00800000);
    rd_reg(6'h20, 32'h0);
    chk_pin(irq0, 1'b0);
    tend("oneshot");
    wr_reg(6'h00, 32'h01c00000);
    wr_reg(6'h04, 32'hb);
    cyc(40);
    wr_reg(6'h00, 32'h01c00000);
    cyc(20);
    rd_reg(6'h20, 32'h1);
    chk_pin(irq0, 1'b0);
    wr_reg(6'h04, 32'h0);
    tend("repeat");
    wr_reg(6'h00, 32'h01e00000);
    wr_reg(6'h18, 32'h2);
    wr_reg(6'h04, 32'h60);
    cyc(40);
    rd_reg(6'h1c, 32'h2);
    u_dpt_pwm_load.burst(5);
    cyc(10);
    rd_reg(6'h20, 32'h2);
    chk_pin(irq1, 1'b0);
    wr_reg(6'h00, 32'h00600000);
    cyc(3);
    chk_pin(irq1, 1'b1);
    tend("external");
    p = pwm0;
    wr_reg(6'h04, 32'h4);
    cyc(3);
    chk_pin(pwm0, ~p);
    wr_reg(6'h04, 32'h10);
    cyc(3);
    chk_pin(pwm1, ~p);
    tend("polarity");
    wr_reg(6'h00, 32'h00600500);
    wr_reg(6'h04, 32'h14);
    cyc(3);
    chk_pin(pwm0, 1'b0);
    chk_pin(pwm1, 1'b0);
    cyc(5);
    chk_pin(pwm0, ~p);
    chk_pin(pwm1, p);
    tend("dead zone");
    wr_reg(6'h00, 32'h02c00000);
    wr_reg(6'h14, 32'h1);
    wr_reg(6'h18, 32'h3);
    wr_reg(6'h04, 32'h1e0);
    cyc(40);
    wr_reg(6'h00, 32'h02c00000);
    cyc(20);
    rd_reg(6'h20, 32'h2);
    wr_reg(6'h04, 32'h180);
    cyc(2);
    p = pwm1;
    wr_reg(6'h04, 32'h100);
    cyc(3);
    chk_pin(pwm1, ~p);
    tend("channel 1");
    test_done();
  end
endmodule
